// file: dv/mac_model.sv
// transmit half of a MAC facing the PHY-side MII port
// assumes the PHY sources the transmit clock watched here
`timescale 1ns/1ps
module mac_model
(
  // clock from the PHY
  input  wire logic  i_tx_clk,
  // transmit nibble and enable
  output logic [3:0] o_txd,
  output logic       o_tx_en
);
  // ****************************************
  // drive on the transmit clock
  // ****************************************
  // quiet lines at start
  initial
  begin
    o_txd   = 4'h0;
    o_tx_en = 1'b0;
  end
  // one nibble, launched just after the clock rise
  task automatic send(input logic [3:0] n);
    @(posedge i_tx_clk);
    o_txd   <= n;
    o_tx_en <= 1'b1;
  endtask
  // idle lines keep moving so a stale nibble never looks valid
  task automatic idle();
    @(posedge i_tx_clk);
    o_txd   <= ~o_txd;
    o_tx_en <= 1'b0;
  endtask
endmodule // mac_model

// file: dv/phy_mii_side_port_bench.sv
// self-checking bench for the PHY-side MII port
// assumes mac_model drives transmit; line side driven here
`timescale 1ns/1ps
module phy_mii_side_port_bench;
  // ****************************************
  // signals
  // ****************************************
  logic       mclk, reset_n, spd, fdx, ldv, ler, lcar, lact;
  logic       mdc, mdrv, mbit, a0, a1, mdc_on;
  logic [3:0] lrxd, txd;
  logic [4:0] maddr;
  logic       tx_en, tx_clk, rx_clk, rx_dv, rx_er, crs, col;
  logic       ltx_en, mdio_o, mdio_oe, match, fast_mdc;
  logic [3:0] rxd, ltxd;
  int         mdc_half, error_cnt, compares;
  // 200 MHz system clock
  always #2.5 mclk = ~mclk;
  // management clock, phase kept off the mclk edges
  always
  begin
    #(mdc_half);
    if (mdc_on) mdc = ~mdc;
  end
  phy_mii_side_port i_dut (.i_mclk(mclk), .i_reset_n(reset_n),
    .i_speed_100(spd), .i_full_duplex(fdx), .i_txd(txd),
    .i_tx_en(tx_en), .o_tx_clk(tx_clk), .o_rx_clk(rx_clk),
    .o_rxd(rxd), .o_rx_dv(rx_dv), .o_rx_er(rx_er), .o_crs(crs),
    .o_col(col), .i_line_rxd(lrxd), .i_line_rx_dv(ldv),
    .i_line_rx_er(ler), .i_line_carrier(lcar),
    .i_line_active(lact), .o_line_txd(ltxd),
    .o_line_tx_en(ltx_en), .i_mdc(mdc), .i_mdio(1'b1),
    .i_mgmt_drive(mdrv), .i_mgmt_bit(mbit), .i_mgmt_addr(maddr),
    .i_phy_addr_sel_bit0(a0), .i_phy_addr_sel_bit1(a1),
    .o_mdio(mdio_o), .o_mdio_oe(mdio_oe), .o_addr_match(match),
    .o_mdc_too_fast(fast_mdc));
  mac_model u_mac (.i_tx_clk(tx_clk), .o_txd(txd), .o_tx_en(tx_en));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic tally_and_finish();
    $display("errors=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // cycles up to the next receive clock rise, bounded
  task automatic wrise(output int c);
    logic p;
    c = 0;
    p = rx_clk;
    while (c <= 200)
    begin
      @(posedge mclk);
      #1;
      c++;
      if (rx_clk === 1'b1 && p === 1'b0) return;
      p = rx_clk;
    end
    // clock never rose: count it and close the run
    error_cnt++;
    tally_and_finish();
  endtask
  // speed is static, so it changes only under reset
  task automatic rst(input logic f);
    @(negedge mclk);
    reset_n = 1'b0;
    spd = f;
    repeat (12) @(negedge mclk);
    chk({tx_clk, rx_clk, rxd, rx_dv, rx_er, crs, col, mdio_o, mdio_oe,
      fast_mdc}, 16'h1804);
    reset_n = 1'b1;
    repeat (4) @(negedge mclk);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic clk_rate(input logic [7:0] p);
    int c;
    wrise(c);
    wrise(c);
    chk(16'(c), 16'(p));
    chk(16'(tx_clk), 16'(rx_clk));
  endtask
  // walking-one nibbles, error mid-frame, then idle
  task automatic rx_frame();
    int c;
    wrise(c);
    for (int k = 0; k < 5; k++)
    begin
      @(negedge mclk);
      ldv = (k < 4);
      lrxd = (k < 4) ? 4'(1 << k) : 4'hF;
      ler = (k == 2);
      wrise(c);
      chk({rxd, rx_dv, rx_er}, (k < 4) ? {4'(1 << k), 1'b1,
        k == 2} : 6'h00);
    end
  endtask
  task automatic crs_run();
    int n;
    @(negedge mclk);
    fdx = 1'b1;
    lcar = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk(16'(crs), 16'h0001);
    @(negedge mclk);
    lcar = 1'b0;
    n = 0;
    while (crs === 1'b1 && n < 20)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk({crs, rx_clk}, 16'h0001);
  endtask
  task automatic tx_run(input logic full, input logic act);
    @(negedge mclk);
    fdx = full;
    lact = act;
    for (int k = 0; k < 6; k++)
    begin
      u_mac.send(4'(1 << (k % 4)));
      #1;
      if (k > 1)
        chk({ltxd, ltx_en, crs, col}, {4'(1 << ((k - 1) % 4)), 1'b1,
          ~full, ~full & act});
    end
    u_mac.idle();
    @(negedge mclk);
    lact = 1'b0;
    repeat (20) @(posedge mclk);
    #1;
    chk({ltx_en, crs, col}, 16'h0000);
  endtask
  task automatic mgmt(input logic [1:0] s, input logic [4:0] a,
    input logic b);
    logic m;
    m = (a == {3'h0, s});
    @(negedge mclk);
    {a1, a0} = s;
    maddr = a;
    mbit = b;
    mdrv = 1'b1;
    repeat (6) @(posedge mclk);
    #1;
    chk({match, mdio_oe, mdio_o}, {m, m, m ? b : 1'b1});
  endtask
  task automatic mdc_run();
    mdc_on = 1'b1;
    repeat (600) @(posedge mclk);
    #1;
    chk(16'(fast_mdc), 16'h0000);
    mdc_half = 32;
    repeat (100) @(posedge mclk);
    #1;
    chk(16'(fast_mdc), 16'h0001);
    mdc_on = 1'b0;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    {mclk, spd, fdx, ldv, ler, lcar, lact, mdc, mdrv, mbit} = '0;
    {a0, a1, mdc_on, lrxd, maddr, reset_n} = '0;
    mdc_half = 101; // slower than the 8 MHz ceiling
    error_cnt = 0;
    compares = 0;
    #1.3;
    rst(1'b0);
    clk_rate(8'h50);
    rst(1'b1);
    clk_rate(8'h08);
    rx_frame();
    crs_run();
    tx_run(1'b1, 1'b1);
    tx_run(1'b0, 1'b0);
    tx_run(1'b0, 1'b1);
    for (int s = 0; s < 4; s++)
      mgmt(2'(s), 5'(s), s[0]);
    mgmt(2'h1, 5'h09, 1'b0);
    mgmt(2'h2, 5'h01, 1'b1);
    @(negedge mclk);
    mdrv = 1'b0;
    repeat (6) @(posedge mclk);
    #1;
    chk({mdio_oe, mdio_o}, 16'h0001);
    mdc_run();
    tally_and_finish();
  end
endmodule // phy_mii_side_port_bench

// file: rtl/mii_port_pkg.sv
// package of constants for the PHY-side MII port
// assumes a 200 MHz system clock drives all logic
package mii_port_pkg;
  // ***************************************************************
  // clock rates
  // ***************************************************************
  localparam int          SYS_CLK_MHZ    = 200;
  localparam int          FAST_NIB_MHZ10 = 250; // 25 MHz, in 0.1 MHz
  localparam int          SLOW_NIB_MHZ10 = 25;  // 2.5 MHz, in 0.1 MHz
  // half periods of the nibble clocks in system cycles
  localparam int          HALF_FAST = (SYS_CLK_MHZ * 10) / (2 * FAST_NIB_MHZ10);
  localparam int          HALF_SLOW = (SYS_CLK_MHZ * 10) / (2 * SLOW_NIB_MHZ10);
  localparam logic [5:0]  HALF_FAST_CNT  = 6'(HALF_FAST);
  localparam logic [5:0]  HALF_SLOW_CNT  = 6'(HALF_SLOW);
  // management clock ceiling and its least half period
  localparam int          MGMT_MAX_MHZ10 = 80;  // 8 MHz, in 0.1 MHz
  localparam int          MGMT_HALF_MIN =
    (SYS_CLK_MHZ * 10 + 2 * MGMT_MAX_MHZ10 - 1) / (2 * MGMT_MAX_MHZ10);
  localparam logic [3:0]  MGMT_HALF_CNT  = 4'(MGMT_HALF_MIN);
  // ***************************************************************
  // widths
  // ***************************************************************
  localparam int          NIB_W          = 4;
  localparam int          PHY_ADDR_W     = 5;
  localparam logic [2:0]  PHY_ADDR_HIGH  = 3'h0;
endpackage

// file: rtl/nib_clk_gen.sv
// nibble clock divider: one toggling clock plus edge pulses
// assumes the speed select is stable or synchronous to i_mclk
`timescale 1ns/1ps
module nib_clk_gen
(
  // clock and reset
  input  wire logic i_mclk,
  input  wire logic i_reset_n,
  // speed select, high for 100 Mbps
  input  wire logic i_fast,
  // nibble clock and its edges
  output logic      o_clk,
  output logic      o_rise,
  output logic      o_fall
);
  logic [5:0] cnt_ff;
  logic [5:0] nxt_cnt;
  logic       clk_ff;
  logic       nxt_clk;
  logic       rise_ff;
  logic       nxt_rise;
  logic       fall_ff;
  logic       nxt_fall;
  logic [5:0] half;

  // ***************************************************************
  // divider
  // ***************************************************************
  // count a half period, then flip the clock
  always_comb
  begin
    half     = i_fast ? mii_port_pkg::HALF_FAST_CNT
                      : mii_port_pkg::HALF_SLOW_CNT;
    nxt_cnt  = cnt_ff + 6'h01;
    nxt_clk  = clk_ff;
    nxt_rise = 1'b0;
    nxt_fall = 1'b0;
    if (cnt_ff >= half - 6'h01)
    begin
      nxt_cnt  = 6'h00;
      nxt_clk  = ~clk_ff;
      nxt_rise = ~clk_ff;
      nxt_fall = clk_ff;
    end
  end

  // registers only; clocks idle high as in hardware reset
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      cnt_ff  <= 6'h00;
      clk_ff  <= 1'b1;
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
    end
    else
    begin
      cnt_ff  <= nxt_cnt;
      clk_ff  <= nxt_clk;
      rise_ff <= nxt_rise;
      fall_ff <= nxt_fall;
    end
  end

  assign o_clk  = clk_ff;
  assign o_rise = rise_ff;
  assign o_fall = fall_ff;
endmodule // nib_clk_gen

// file: rtl/phy_mii_side_port.sv
// PHY side of the media independent interface: nibble clocks,
// transmit capture, receive drive, carrier sense and collision
// assumes the line side hands in receive nibbles on i_mclk and
// a MAC on the far side drives transmit on our transmit clock
`timescale 1ns/1ps
// Contract
// [R1] MAC changes transmit nibble on transmit clock
// [R2] MAC holds tx enable during valid nibbles
// [R3] PHY sources both clocks, 2.5/25 MHz
// [R4] receive nibble changes on receive clock
// [R5] rx data valid marks exactly valid nibbles
// [R6] rx error flags receive error, clocked
// [R7] collision high for whole collision
// [R8] collision asynchronous, low in full duplex
// [R9] half duplex: carrier on transmit or receive
// [R10] full duplex: carrier only on receive
// [R11] carrier may rise at any time
// [R12] carrier drops on receive clock
// [R13] management clock no faster than 8 MHz
// [R14] management line driven only in own turn
// [R15] answer only matching strapped address bits
module phy_mii_side_port
(
  // clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_reset_n,
  // mode controls
  input  wire logic       i_speed_100,
  input  wire logic       i_full_duplex,
  // MII transmit side from the MAC
  input  wire logic [3:0] i_txd,
  input  wire logic       i_tx_en,
  output logic            o_tx_clk,
  // MII receive side to the MAC
  output logic            o_rx_clk,
  output logic [3:0]      o_rxd,
  output logic            o_rx_dv,
  output logic            o_rx_er,
  output logic            o_crs,
  output logic            o_col,
  // line side
  input  wire logic [3:0] i_line_rxd,
  input  wire logic       i_line_rx_dv,
  input  wire logic       i_line_rx_er,
  input  wire logic       i_line_carrier,
  input  wire logic       i_line_active,
  output logic [3:0]      o_line_txd,
  output logic            o_line_tx_en,
  // management pins and address straps
  input  wire logic       i_mdc,
  input  wire logic       i_mdio,
  input  wire logic       i_mgmt_drive,
  input  wire logic       i_mgmt_bit,
  input  wire logic [4:0] i_mgmt_addr,
  input  wire logic       i_phy_addr_sel_bit0,
  input  wire logic       i_phy_addr_sel_bit1,
  output logic            o_mdio,
  output logic            o_mdio_oe,
  output logic            o_addr_match,
  output logic            o_mdc_too_fast
);
  // ***************************************************************
  // nibble clocks
  // ***************************************************************
  logic nclk;
  logic nrise;
  logic nfall;

  // one divider feeds both clocks so they stay in phase
  nib_clk_gen u_nclk
  (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_fast    (i_speed_100),
    .o_clk     (nclk),
    .o_rise    (nrise),
    .o_fall    (nfall)
  );
  assign o_tx_clk = nclk; // [R3]
  assign o_rx_clk = nclk; // [R3]

  // ***************************************************************
  // input synchronisers
  // ***************************************************************
  logic [8:0] s1_ff;
  logic [8:0] s2_ff;
  logic [3:0] ts_txd;
  logic       ts_en;
  logic       sm_mdc;
  logic       sm_mdio;
  logic [1:0] sa_strap;

  // two flops on each pin-facing input
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      s1_ff <= 9'h000;
      s2_ff <= 9'h000;
    end
    else
    begin
      s1_ff <= {i_phy_addr_sel_bit1, i_phy_addr_sel_bit0, i_mdio,
                i_mdc, i_tx_en, i_txd};
      s2_ff <= s1_ff;
    end
  end
  // nibble and enable share one stage so they stay aligned
  assign ts_txd   = s2_ff[3:0];
  assign ts_en    = s2_ff[4];
  assign sm_mdc   = s2_ff[5];
  assign sm_mdio  = s2_ff[6];
  assign sa_strap = s2_ff[8:7];

  // ***************************************************************
  // transmit capture and receive drive
  // ***************************************************************
  logic [3:0] ltxd_ff;
  logic [3:0] nxt_ltxd;
  logic       lten_ff;
  logic       nxt_lten;
  logic [3:0] rxd_ff;
  logic [3:0] nxt_rxd;
  logic       dv_ff;
  logic       nxt_dv;
  logic       er_ff;
  logic       nxt_er;

  // the MAC changes data on our rising edge, so we sample on
  // falling edge, half a period away from any change
  always_comb
  begin
    nxt_ltxd = ltxd_ff;
    nxt_lten = lten_ff;
    nxt_rxd  = rxd_ff;
    nxt_dv   = dv_ff;
    nxt_er   = er_ff;
    if (nfall)
    begin
      nxt_ltxd = ts_en ? ts_txd : 4'h0; // [R1]
      nxt_lten = ts_en;                 // [R2]
    end
    if (nrise)
    begin
      nxt_rxd = i_line_rx_dv ? i_line_rxd : 4'h0; // [R4]
      nxt_dv  = i_line_rx_dv;                     // [R5]
      nxt_er  = i_line_rx_er;                     // [R6]
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      ltxd_ff <= 4'h0;
      lten_ff <= 1'b0;
      rxd_ff  <= 4'h0;
      dv_ff   <= 1'b0;
      er_ff   <= 1'b0;
    end
    else
    begin
      ltxd_ff <= nxt_ltxd;
      lten_ff <= nxt_lten;
      rxd_ff  <= nxt_rxd;
      dv_ff   <= nxt_dv;
      er_ff   <= nxt_er;
    end
  end
  assign o_line_txd   = ltxd_ff;
  assign o_line_tx_en = lten_ff;
  assign o_rxd        = rxd_ff;
  assign o_rx_dv      = dv_ff;
  assign o_rx_er      = er_ff;

  // ***************************************************************
  // carrier sense and collision
  // ***************************************************************
  logic crs_ff;
  logic nxt_crs;
  logic col_ff;
  logic nxt_col;
  logic sense;

  // rise at once, fall only on a receive clock edge
  always_comb
  begin
    sense   = i_line_carrier | (~i_full_duplex & lten_ff); // [R9] [R10]
    nxt_crs = crs_ff;
    if (sense)
      nxt_crs = 1'b1;             // [R11]
    else if (nrise)
      nxt_crs = 1'b0;             // [R12]
    // collision follows the line with no clock alignment
    nxt_col = ~i_full_duplex & lten_ff & i_line_active; // [R7] [R8]
  end

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      crs_ff <= 1'b0;
      col_ff <= 1'b0;
    end
    else
    begin
      crs_ff <= nxt_crs;
      col_ff <= nxt_col;
    end
  end
  assign o_crs = crs_ff;
  assign o_col = col_ff;

  // ***************************************************************
  // management pin and address match
  // ***************************************************************
  logic       match_ff;
  logic       nxt_match;
  logic       md_ff;
  logic       nxt_md;
  logic       oe_ff;
  logic       nxt_oe;
  logic       mdc_d_ff;
  logic       fast_ff;
  logic       nxt_fast;
  logic [3:0] hcnt_ff;
  logic [3:0] nxt_hcnt;

  // only low two address bits are strapped, the rest fixed
  always_comb
  begin
    nxt_match = (i_mgmt_addr ==
      {mii_port_pkg::PHY_ADDR_HIGH, sa_strap});        // [R15]
    nxt_oe    = i_mgmt_drive & nxt_match;            // [R14]
    nxt_md    = nxt_oe ? i_mgmt_bit : 1'b1;           // [R14]
    // flag a management half period shorter than allowed
    nxt_hcnt  = (sm_mdc != mdc_d_ff) ? 4'h0
              : (hcnt_ff == 4'hF ? hcnt_ff : hcnt_ff + 4'h1);
    nxt_fast  = fast_ff;
    if ((sm_mdc != mdc_d_ff) &&
        (hcnt_ff < mii_port_pkg::MGMT_HALF_CNT - 4'h1))
      nxt_fast = 1'b1;                                // [R13]
  end

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      match_ff <= 1'b0;
      md_ff    <= 1'b1;
      oe_ff    <= 1'b0;
      mdc_d_ff <= 1'b0;
      fast_ff  <= 1'b0;
      hcnt_ff  <= 4'hF;
    end
    else
    begin
      match_ff <= nxt_match;
      md_ff    <= nxt_md;
      oe_ff    <= nxt_oe;
      mdc_d_ff <= sm_mdc;
      fast_ff  <= nxt_fast;
      hcnt_ff  <= nxt_hcnt;
    end
  end
  assign o_addr_match   = match_ff;
  assign o_mdio         = md_ff;
  assign o_mdio_oe      = oe_ff;
  assign o_mdc_too_fast = fast_ff;

  // ***************************************************************
  // checks
  // ***************************************************************
  rx_valid_data_a: assert property (@(posedge i_mclk) disable iff
    (!i_reset_n) nrise |=> (o_rx_dv == $past(i_line_rx_dv)))  // [R5]
    else $error("rx valid not taken on clock edge");
  rxd_edge_a: assert property (@(posedge i_mclk) disable iff
    (!i_reset_n) !$past(nrise) |-> $stable(o_rxd))            // [R4]
    else $error("rx nibble moved off clock edge");
  rx_err_edge_a: assert property (@(posedge i_mclk) disable iff
    (!i_reset_n) !$past(nrise) |-> $stable(o_rx_er))          // [R6]
    else $error("rx error moved off clock edge");
  col_full_dup_a: assert property (@(posedge i_mclk) disable iff
    (!i_reset_n) i_full_duplex ##1 i_full_duplex |-> !o_col)  // [R8]
    else $error("collision in full duplex");
  crs_fall_edge_a: assert property (@(posedge i_mclk) disable iff
    (!i_reset_n) $fell(o_crs) |-> $past(nrise))               // [R12]
    else $error("carrier dropped off clock edge");
  crs_half_tx_a: assert property (@(posedge i_mclk) disable iff
    (!i_reset_n) (!i_full_duplex && lten_ff) |=> o_crs)       // [R9]
    else $error("carrier missing during transmit");
  crs_rise_a: assert property (@(posedge i_mclk) disable iff
    (!i_reset_n) i_line_carrier |=> o_crs)                    // [R11]
    else $error("carrier late on receive");
  mdio_turn_a: assert property (@(posedge i_mclk) disable iff
    (!i_reset_n) o_mdio_oe |-> o_addr_match)                  // [R14]
    else $error("management line driven without match");
endmodule // phy_mii_side_port
